// >>> src/ntp_sram_dev.sv
// Device end: pipelined no-turnaround synchronous SRAM array
// Contract
// - Sample inputs on clock edge, except async ones
// - Clock hold freezes the pipeline; sleep synchroniser and power state keep running
// - Start cycle when enabled, loading, selected
// - Read data driven from the second edge
// - Host holds output enable low for reads
// - Write data arrives two cycles after command
// - Byte lane strobes choose written lanes
// - Advance high continues burst internally
// - Low address bits seed burst counter
// - Burst wraps to start after four beats
// - Linear order increments modulo four
// - Interleaved order xors beat count
// - Burst order select tied static
// - Host loads new address after deselect
// - Output enable disables outputs asynchronously
// - Reads and writes back to back
// - Sleep entered two cycles after request
// - Wake two cycles after request drops
// - Continue deselect only after deselect
`timescale 1ns/1ps
`default_nettype none
module ntp_sram_dev
  import ntp_pkg::*;
#(
  parameter int MEM_BITS = ADDR_W
) (
  input wire logic clock,
  input wire logic srst,
  ntp_if.dev bus,
  output logic asleep
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MEM_BITS < BURST_W || MEM_BITS > ADDR_W) begin : g_chk
    $error("MEM_BITS out of range");
  end

  localparam int DEPTH = 1 << MEM_BITS;

  // Lane merge of new data over old under active-low strobes
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [LANES-1:0] strobe_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!strobe_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    lane_merge = res;
  endfunction

  // ----------------------------------------------------------------
  // Sleep request synchroniser
  // ----------------------------------------------------------------
  logic sleep_m_q;
  logic sleep_s_q;

  // Two stages; only the second is read
  always_ff @(posedge clock) begin
    if (srst) begin
      sleep_m_q <= 1'b0;
      sleep_s_q <= 1'b0;
    end else begin
      sleep_m_q <= bus.sleep_request;
      sleep_s_q <= sleep_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  ntp_pwr_t pwr_q;
  ntp_pwr_t pwr_d;
  logic [1:0] pcnt_q;
  logic [1:0] pcnt_d;
  logic awake;
  logic run;

  // Entry and wake counters
  always_comb begin
    pwr_d = pwr_q;
    pcnt_d = pcnt_q;
    case (pwr_q)
      NTP_AWAKE: begin
        if (sleep_s_q) begin
          pwr_d = NTP_ENTERING;
          pcnt_d = 2'h1;
        end
      end
      NTP_ENTERING: begin
        if (!sleep_s_q) begin
          pwr_d = NTP_AWAKE;
        end else if (pcnt_q == SLEEP_ENTRY_CYC) begin
          pwr_d = NTP_ASLEEP;
        end else begin
          pcnt_d = pcnt_q + 2'h1;
        end
      end
      NTP_ASLEEP: begin
        if (!sleep_s_q) begin
          pwr_d = NTP_WAKING;
          pcnt_d = 2'h1;
        end
      end
      NTP_WAKING: begin
        if (sleep_s_q) begin
          pwr_d = NTP_ASLEEP;
        end else if (pcnt_q == WAKE_CYC) begin
          pwr_d = NTP_AWAKE;
        end else begin
          pcnt_d = pcnt_q + 2'h1;
        end
      end
      default: begin
        pwr_d = NTP_AWAKE;
      end
    endcase
  end

  // Power state registers
  always_ff @(posedge clock) begin
    if (srst) begin
      pwr_q <= NTP_AWAKE;
      pcnt_q <= CNT_RST;
    end else begin
      pwr_q <= pwr_d;
      pcnt_q <= pcnt_d;
    end
  end

  // Sleep keeps state by freezing the pipeline like clock hold
  assign awake = (pwr_q == NTP_AWAKE) || (pwr_q == NTP_ENTERING);
  assign run = awake && !bus.clk_hold;
  assign asleep = !awake;

  // ----------------------------------------------------------------
  // Command decode, burst counter and pipeline
  // ----------------------------------------------------------------
  ntp_op_t last_q;
  ntp_op_t last_d;
  ntp_op_t s1_op_q;
  ntp_op_t s1_op_d;
  ntp_op_t s2_op_q;
  ntp_op_t s2_op_d;
  logic [ADDR_W-1:0] s1_addr_q;
  logic [ADDR_W-1:0] s1_addr_d;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [ADDR_W-1:0] s2_addr_d;
  logic [BURST_W-1:0] base_q;
  logic [BURST_W-1:0] base_d;
  logic [BURST_W-1:0] beat_q;
  logic [BURST_W-1:0] beat_d;
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] out_d;
  logic drive_q;
  logic drive_d;
  logic selected;
  logic [ADDR_W-1:BURST_W] hi_addr;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wr_word;
  logic mem_we;

  assign selected = !bus.chip_sel_a_n && bus.chip_sel_b &&
                    !bus.chip_sel_c_n;

  // Late-late write word, merged over the stored word per lane
  assign wr_word = lane_merge(mem[s2_addr_q[MEM_BITS-1:0]], bus.dq,
                              bus.byte_lane_write_n);
  assign mem_we = run && (s2_op_q == NTP_WRITE);

  // Read sees a write landing on the same edge to the same word
  always_comb begin
    rd_word = mem[s1_addr_q[MEM_BITS-1:0]];
    if (mem_we && (s2_addr_q[MEM_BITS-1:0] ==
                   s1_addr_q[MEM_BITS-1:0])) begin
      rd_word = wr_word;
    end
  end

  // Next command, burst position and read stage
  always_comb begin
    last_d = last_q;
    base_d = base_q;
    beat_d = beat_q;
    hi_addr = s1_addr_q[ADDR_W-1:BURST_W];
    s1_op_d = NTP_DESEL;
    if (!bus.advance_load) begin
      base_d = bus.addr[BURST_W-1:0];
      beat_d = BEAT_RST;
      hi_addr = bus.addr[ADDR_W-1:BURST_W];
      if (selected) begin
        s1_op_d = bus.read_sel ? NTP_READ : NTP_WRITE;
      end
    end else if (last_q != NTP_DESEL) begin
      beat_d = beat_q + 2'h1;
      s1_op_d = last_q;
    end
    // Continue after a deselect stays deselected
    last_d = s1_op_d;
    s1_addr_d = {hi_addr,
                 ntp_burst_lsb(base_d, beat_d,
                               bus.burst_order_select)};
    s2_op_d = s1_op_q;
    s2_addr_d = s1_addr_q;
    out_d = out_q;
    drive_d = 1'b0;
    if (s1_op_q == NTP_READ) begin
      out_d = rd_word;
      drive_d = 1'b1;
    end
  end

  // Pipeline registers advance only while running
  always_ff @(posedge clock) begin
    if (srst) begin
      last_q <= NTP_DESEL;
      s1_op_q <= NTP_DESEL;
      s2_op_q <= NTP_DESEL;
      s1_addr_q <= '0;
      s2_addr_q <= '0;
      base_q <= BEAT_RST;
      beat_q <= BEAT_RST;
      out_q <= '0;
      drive_q <= 1'b0;
    end else if (run) begin
      last_q <= last_d;
      s1_op_q <= s1_op_d;
      s2_op_q <= s2_op_d;
      s1_addr_q <= s1_addr_d;
      s2_addr_q <= s2_addr_d;
      base_q <= base_d;
      beat_q <= beat_d;
      out_q <= out_d;
      drive_q <= drive_d;
    end
  end

  // Array storage, not reset
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[s2_addr_q[MEM_BITS-1:0]] <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  assign bus.dev_dq_o = out_q;
  // Output enable gates the driver without waiting for a clock edge
  assign bus.dev_dq_oe_n = !(drive_q && awake &&
                             !bus.out_enable_n);

endmodule
`default_nettype wire

// >>> include/ntp_pkg.sv
// Shared constants, types and helpers for the no-turnaround SRAM port
package ntp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------
  // Timing in clock cycles
  // ----------------------------------------------------------------
  localparam int WRITE_LAT = 2;
  localparam logic [1:0] SLEEP_ENTRY_CYC = 2'h2;
  localparam logic [1:0] WAKE_CYC = 2'h2;
  // Host guard after sleep drops: pin register, two sync stages, wake
  localparam logic [2:0] HOST_WAKE_GUARD = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic [1:0] CNT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {NTP_DESEL, NTP_READ, NTP_WRITE} ntp_op_t;
  typedef enum logic [1:0] {
    NTP_AWAKE, NTP_ENTERING, NTP_ASLEEP, NTP_WAKING
  } ntp_pwr_t;

  // Burst address low bits: linear adds the beat, interleaved xors it
  function automatic logic [BURST_W-1:0] ntp_burst_lsb(
    input logic [BURST_W-1:0] base,
    input logic [BURST_W-1:0] beat,
    input logic interleave
  );
    ntp_burst_lsb = interleave ? (base ^ beat) : (base + beat);
  endfunction

endpackage

// >>> include/ntp_if.sv
// Pin bundle between the SRAM port and its host controller
`timescale 1ns/1ps
`default_nettype none
interface ntp_if;
  import ntp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic advance_load;
  logic read_sel;
  logic clk_hold;
  logic chip_sel_a_n;
  logic chip_sel_b;
  logic chip_sel_c_n;
  logic [LANES-1:0] byte_lane_write_n;
  logic out_enable_n;
  logic sleep_request;
  logic burst_order_select;
  logic [DATA_W-1:0] host_dq_o;
  logic host_dq_oe_n;
  logic [DATA_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic [DATA_W-1:0] dq;
  logic [LANE_W-1:0] data_lane_low;
  logic [LANE_W-1:0] data_lane_high;

  // Resolved bus level; an undriven bus reads as zero
  assign dq = !dev_dq_oe_n ? dev_dq_o :
              (!host_dq_oe_n ? host_dq_o : '0);
  assign data_lane_low = dq[LANE_W-1:0];
  assign data_lane_high = dq[DATA_W-1:LANE_W];

  modport dev (
    input addr, advance_load, read_sel, clk_hold, chip_sel_a_n,
    input chip_sel_b, chip_sel_c_n, byte_lane_write_n, out_enable_n,
    input sleep_request, burst_order_select, dq,
    output dev_dq_o, dev_dq_oe_n
  );
  modport host (
    output addr, advance_load, read_sel, clk_hold, chip_sel_a_n,
    output chip_sel_b, chip_sel_c_n, byte_lane_write_n, out_enable_n,
    output sleep_request, burst_order_select, host_dq_o, host_dq_oe_n,
    input dq
  );
endinterface
`default_nettype wire

// >>> src/ntp_sram_host.sv
// Host end: controller driving the SRAM pins from a command port
`timescale 1ns/1ps
`default_nettype none
module ntp_sram_host
  import ntp_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  ntp_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_continue,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic [LANES-1:0] cmd_lanes_n,
  input wire logic hold,
  input wire logic sleep,
  input wire logic order_interleave,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ntp_op_t last_q, last_d, op0_q, op0_d, op1_q, op1_d, op2_q, op2_d;
  logic [DATA_W-1:0] wd0_q, wd0_d, wd1_q, wd1_d, dqo_q, dqo_d;
  logic [LANES-1:0] ln0_q, ln0_d, ln1_q, ln1_d, lnp_q, lnp_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic aload_q, aload_d, rsel_q, rsel_d, csa_n_q, csa_n_d;
  logic hold_q, hold_d, sleep_q, sleep_d, order_q, order_d;
  logic dq_oe_n_q, dq_oe_n_d, oe_n_q, oe_n_d;
  logic rdv_q, rdv_d;
  logic [DATA_W-1:0] rdd_q, rdd_d;
  logic [2:0] wake_q, wake_d;
  logic accept;

  // Commands wait out hold, sleep and wake-up
  assign cmd_ready = !hold && !bus.clk_hold && !sleep && !sleep_q &&
                     (wake_q == 3'h0);
  assign accept = cmd_valid && cmd_ready;

  // Next pin values and data pipeline
  always_comb begin
    // Operation stages kept one by one so each stays its own enum type
    last_d = last_q;
    op0_d = op0_q;
    op1_d = op1_q;
    op2_d = op2_q;
    {wd0_d, wd1_d, dqo_d} = {wd0_q, wd1_q, dqo_q};
    {ln0_d, ln1_d, lnp_d} = {ln0_q, ln1_q, lnp_q};
    {addr_d, aload_d, rsel_d, csa_n_d} = {addr_q, aload_q, rsel_q, csa_n_q};
    {dq_oe_n_d, oe_n_d, rdd_d} = {dq_oe_n_q, oe_n_q, rdd_q};
    hold_d = hold;
    sleep_d = sleep;
    order_d = order_interleave;
    wake_d = sleep_q ? HOST_WAKE_GUARD :
             ((wake_q != 3'h0) ? wake_q - 3'h1 : 3'h0);
    rdv_d = 1'b0;
    // Command stage; idle sends a deselect with a fresh load
    if (!bus.clk_hold) begin
      aload_d = 1'b0;
      csa_n_d = 1'b1;
      op0_d = NTP_DESEL;
      if (accept) begin
        addr_d = cmd_addr;
        rsel_d = !cmd_write;
        wd0_d = cmd_wdata;
        ln0_d = cmd_lanes_n;
        if (cmd_continue) begin
          aload_d = 1'b1;
          op0_d = last_q;
        end else begin
          csa_n_d = 1'b0;
          op0_d = cmd_write ? NTP_WRITE : NTP_READ;
        end
      end
      last_d = op0_d;
    end
    // Data stages frozen on the edges the device ignores
    if (!hold_q) begin
      op1_d = op0_q;
      wd1_d = wd0_q;
      ln1_d = ln0_q;
      op2_d = op1_q;
      dq_oe_n_d = (op1_q != NTP_WRITE);
      dqo_d = wd1_q;
      lnp_d = (op1_q == NTP_WRITE) ? ln1_q : '1;
      oe_n_d = (op1_q != NTP_READ);
      if (op2_q == NTP_READ) begin
        rdv_d = 1'b1;
        rdd_d = bus.dq;
      end
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (srst) begin
      last_q <= NTP_DESEL;
      op0_q <= NTP_DESEL;
      op1_q <= NTP_DESEL;
      op2_q <= NTP_DESEL;
      {wd0_q, wd1_q, dqo_q, rdd_q} <= '0;
      {ln0_q, ln1_q, lnp_q} <= '1;
      addr_q <= '0;
      {aload_q, rsel_q, csa_n_q} <= 3'h3;
      {hold_q, sleep_q, order_q, rdv_q} <= 4'h0;
      {dq_oe_n_q, oe_n_q} <= 2'h3;
      wake_q <= 3'h0;
    end else begin
      last_q <= last_d;
      op0_q <= op0_d;
      op1_q <= op1_d;
      op2_q <= op2_d;
      {wd0_q, wd1_q, dqo_q, rdd_q} <= {wd0_d, wd1_d, dqo_d, rdd_d};
      {ln0_q, ln1_q, lnp_q} <= {ln0_d, ln1_d, lnp_d};
      addr_q <= addr_d;
      {aload_q, rsel_q, csa_n_q} <= {aload_d, rsel_d, csa_n_d};
      {hold_q, sleep_q, order_q, rdv_q} <= {hold_d, sleep_d, order_d,
                                            rdv_d};
      {dq_oe_n_q, oe_n_q} <= {dq_oe_n_d, oe_n_d};
      wake_q <= wake_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign bus.addr = addr_q;
  assign bus.advance_load = aload_q;
  assign bus.read_sel = rsel_q;
  assign bus.clk_hold = hold_q;
  assign bus.chip_sel_a_n = csa_n_q;
  assign bus.chip_sel_b = !csa_n_q;
  assign bus.chip_sel_c_n = csa_n_q;
  assign bus.byte_lane_write_n = lnp_q;
  assign bus.out_enable_n = oe_n_q;
  assign bus.sleep_request = sleep_q;
  assign bus.burst_order_select = order_q;
  assign bus.host_dq_o = dqo_q;
  assign bus.host_dq_oe_n = dq_oe_n_q;
  assign rd_valid = rdv_q;
  assign rd_data = rdd_q;

endmodule
`default_nettype wire

// >>> verification/ntp_port_properties.sv
// Pin-level checks between the SRAM port and its host controller
`timescale 1ns/1ps
`default_nettype none
module ntp_port_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic advance_load,
  input wire logic read_sel,
  input wire logic clk_hold,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq_oe_n
);
  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  logic sel;
  logic go;
  logic desel;
  // Start and deselect edges as the device sees them
  assign sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  assign go = !clk_hold && !advance_load && sel && !sleep_request;
  assign desel = !clk_hold && !advance_load && !sel;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_oe_gates_drive: assert property (!dev_dq_oe_n |-> !out_enable_n)
    else $error("device drives with output enable off");
  a_no_contention: assert property (dev_dq_oe_n || host_dq_oe_n)
    else $error("both ends drive the data bus");
  a_read_drive_slot: assert property (
    (go && read_sel) ##1 !clk_hold |-> ##1 !dev_dq_oe_n)
    else $error("read data not driven at second edge");
  a_read_oe_low: assert property (
    (go && read_sel) ##1 !clk_hold |-> ##1 !out_enable_n)
    else $error("host output enable high during read");
  a_write_data_slot: assert property (
    (go && !read_sel) ##1 !clk_hold |-> ##1 !host_dq_oe_n)
    else $error("write data not driven two cycles later");
  a_write_bus_free: assert property (
    (go && !read_sel) ##1 !clk_hold |-> ##1 dev_dq_oe_n)
    else $error("device drives in a write data slot");
  a_desel_quiet: assert property (
    desel ##1 !clk_hold |-> ##1 dev_dq_oe_n)
    else $error("device drives after a deselect");
  a_cont_desel: assert property (
    desel ##1 (!clk_hold && advance_load) ##1 !clk_hold
    |-> ##1 (dev_dq_oe_n && host_dq_oe_n))
    else $error("continued deselect moved data");
  a_hold_freezes: assert property (
    (!$past(srst) && $past(clk_hold) && $stable(out_enable_n))
    |-> $stable(dev_dq_oe_n))
    else $error("device output changed under clock hold");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench joining host and device ends of the SRAM port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ntp_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_write = 1'h0;
  logic cmd_continue = 1'h0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic [LANES-1:0] cmd_lanes_n = 2'h3;
  logic hold = 1'h0;
  logic sleep = 1'h0;
  logic order_interleave = 1'h0;
  logic cmd_ready;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic asleep;
  logic [DATA_W-1:0] lanes_q;
  logic [DATA_W-1:0] mem [0:63];
  logic [DATA_W-1:0] rq [$];
  logic [DATA_W-1:0] eq [$];
  int n_mismatch = 0;
  int samples_checked = 0;

  ntp_if bus_if ();
  ntp_sram_dev #(.MEM_BITS(6)) i_ntp_sram_dev (.clock(clock),
    .srst(srst), .bus(bus_if), .asleep(asleep));
  ntp_sram_host i_ntp_sram_host (.clock(clock), .srst(srst), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_continue(cmd_continue), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_lanes_n(cmd_lanes_n), .hold(hold),
    .sleep(sleep), .order_interleave(order_interleave),
    .rd_valid(rd_valid), .rd_data(rd_data));
  ntp_port_properties i_ntp_port_properties (.clock(clock), .srst(srst),
    .advance_load(bus_if.advance_load), .read_sel(bus_if.read_sel),
    .clk_hold(bus_if.clk_hold), .chip_sel_a_n(bus_if.chip_sel_a_n),
    .chip_sel_b(bus_if.chip_sel_b), .chip_sel_c_n(bus_if.chip_sel_c_n),
    .out_enable_n(bus_if.out_enable_n),
    .sleep_request(bus_if.sleep_request),
    .host_dq_oe_n(bus_if.host_dq_oe_n), .dev_dq_oe_n(bus_if.dev_dq_oe_n));

  // Clock at 50 MHz
  initial begin
    forever #10 clock = ~clock;
  end

  // Collect every returned read word; it must match the lanes it came on
  always @(posedge clock) begin
    lanes_q <= {bus_if.data_lane_high, bus_if.data_lane_low};
    if (rd_valid === 1'h1) begin
      rq.push_back(rd_data);
      check("data lanes", rd_data, lanes_q);
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Offer one command and hold it until the edge that takes it
  task automatic cmd(input logic w, input logic c, input int a,
                     input logic [DATA_W-1:0] d, input logic [LANES-1:0] l);
    int n;
    n = 0;
    cmd_valid <= 1'h1;
    cmd_write <= w;
    cmd_continue <= c;
    cmd_addr <= ADDR_W'(a);
    cmd_wdata <= d;
    cmd_lanes_n <= l;
    @(posedge clock);
    while (cmd_ready !== 1'h1) begin
      n++;
      if (n > 40) begin
        n_mismatch++;
        tally_and_finish();
      end
      @(posedge clock);
    end
  endtask

  // Write with lane merge into the reference copy
  task automatic wr(input int a, input logic [DATA_W-1:0] d,
                    input logic [LANES-1:0] l);
    cmd(1'h1, 1'h0, a, d, l);
    if (!l[0]) mem[a][LANE_W-1:0] = d[LANE_W-1:0];
    if (!l[1]) mem[a][DATA_W-1:LANE_W] = d[DATA_W-1:LANE_W];
  endtask

  task automatic rd(input int a, input logic c);
    cmd(1'h0, c, a, '0, 2'h3);
    eq.push_back(mem[a]);
  endtask

  // Let the pipeline empty, then compare returned words in order
  task automatic drain();
    cmd_valid <= 1'h0;
    repeat (12) @(posedge clock);
    check("read count", rq.size(), eq.size());
    foreach (eq[i]) begin
      if (i < rq.size()) check("rd_data", rq[i], eq[i]);
    end
    rq.delete();
    eq.delete();
  endtask

  task automatic until_asleep(input logic v);
    int n;
    n = 0;
    while (asleep !== v && n < 12) begin
      @(posedge clock);
      n++;
    end
    check("asleep", asleep, v);
    if (asleep !== v) tally_and_finish();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Alternating writes and reads with partial lanes and an abort
  task automatic t_back_to_back();
    for (int i = 0; i < 4; i++) begin
      wr(8 + i, 18'h25AC3 + 18'(i), 2'h0);
      rd(8 + i, 1'h0);
    end
    wr(8, 18'h3FFFF, 2'h2);
    rd(8, 1'h0);
    wr(9, 18'h00000, 2'h1);
    rd(9, 1'h0);
    wr(10, 18'h1234A, 2'h3);
    rd(10, 1'h0);
    drain();
  endtask

  // Five-beat read from start 1 shows the order and the wrap
  task automatic t_burst(input logic ord);
    int s;
    order_interleave <= ord;
    cmd_valid <= 1'h0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      wr(32 + i, 18'h1F000 + 18'(ord * 16 + i), 2'h0);
    end
    for (int i = 0; i < 5; i++) begin
      s = ord ? ((1 ^ i) & 3) : ((1 + i) & 3);
      rd(32 + s, i > 0);
    end
    drain();
  endtask

  // Clock hold right after a read must not lose or alter it
  task automatic t_hold();
    wr(40, 18'h2D2D2, 2'h0);
    rd(40, 1'h0);
    hold <= 1'h1;
    cmd_valid <= 1'h0;
    repeat (4) @(posedge clock);
    hold <= 1'h0;
    drain();
  endtask

  // Sleep and wake keep the stored words
  task automatic t_sleep();
    sleep <= 1'h1;
    cmd_valid <= 1'h0;
    until_asleep(1'h1);
    check("cmd_ready", cmd_ready, 1'h0);
    sleep <= 1'h0;
    until_asleep(1'h0);
    rd(40, 1'h0);
    rd(9, 1'h0);
    drain();
  endtask

  // A continue after idle stays deselected
  task automatic t_cont_desel();
    cmd_valid <= 1'h0;
    repeat (3) @(posedge clock);
    cmd(1'h0, 1'h1, 40, '0, 2'h3);
    drain();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    t_back_to_back();
    t_burst(1'h0);
    t_burst(1'h1);
    t_hold();
    t_sleep();
    t_cont_desel();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
